// File: flash_status_regs.svh
/*
 * Status register layout, instruction codes and frame lengths of the
 * status and write-enable block.
 * Assumes it is included by bare name at file level, ahead of the module.
 */
`ifndef FLASH_STATUS_REGS_SVH
`define FLASH_STATUS_REGS_SVH

// Status register bit positions
`define SR_LOCK_BIT 3'd7
`define SR_FOUR_LINE_BIT 3'd6
`define SR_BP_MSB 3'd5
`define SR_BP_LSB 3'd2
`define SR_WEL_BIT 3'd1
`define SR_BUSY_BIT 3'd0
`define SR_RESET_VAL 8'h00
`define SR_NV_RESET_VAL 6'h00

// Instruction codes
`define OPC_STATUS_WRITE 8'h01
`define OPC_PAGE_PROG 8'h02
`define OPC_PAGE_PROG_4A 8'h32
`define OPC_PAGE_PROG_4B 8'h38
`define OPC_SECTOR_ERASE_A 8'hD7
`define OPC_SECTOR_ERASE_B 8'h20
`define OPC_HALF_BLOCK_ERASE 8'h52
`define OPC_BLOCK_ERASE 8'hD8
`define OPC_ARRAY_ERASE_A 8'hC7
`define OPC_ARRAY_ERASE_B 8'h60
`define OPC_FUNC_WRITE 8'h42
`define OPC_INFO_ERASE 8'h64
`define OPC_INFO_PROG 8'h62
`define OPC_SLEEP_ENTER 8'hB9
`define OPC_SLEEP_EXIT 8'hAB
`define OPC_SUSPEND 8'h75
`define OPC_RESUME 8'h7A

// Frame lengths in serial clock edges
`define LEN_OPCODE 6'd8
`define LEN_REG_WRITE 6'd16
`define LEN_ADDR 6'd32
`define LEN_PROG_MIN 6'd40
`define LEN_SAT 6'd63

`endif

// File: flash_status_pkg.sv
/*
 * Types shared by the status and write-enable block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package flash_status_pkg;

    // Serial frame phase, one-hot
    typedef enum logic [4:0] {
        PH_IDLE = 5'b00001,
        PH_OPCODE = 5'b00010,
        PH_BODY = 5'b00100,
        PH_STATUS_OUT = 5'b01000,
        PH_IGNORE = 5'b10000
    } phase_type;

    // Operation handed to the array engine or volatile registers
    typedef enum logic [3:0] {
        OPK_NONE = 4'h0,
        OPK_PROG = 4'h1,
        OPK_PROG4 = 4'h2,
        OPK_ERASE_SECTOR = 4'h3,
        OPK_ERASE_HALF = 4'h4,
        OPK_ERASE_BLOCK = 4'h5,
        OPK_ERASE_ALL = 4'h6,
        OPK_STATUS_WR = 4'h7,
        OPK_FUNC_WR = 4'h8,
        OPK_INFO_ERASE = 4'h9,
        OPK_INFO_PROG = 4'hA,
        OPK_VOL_READ = 4'hB,
        OPK_VOL_EXT = 4'hC
    } op_kind_type;

    typedef struct packed {
        op_kind_type kind;
        logic [23:0] addr;
        logic [7:0] data;
    } cmd_req_type;

    typedef struct packed {
        phase_type phase;
        logic sck;
        logic cs_n;
        logic [5:0] cnt;
        logic [31:0] shreg;
        logic [7:0] opcode;
        logic [5:0] nv;
        logic [5:0] pend;
        logic write_enable_latch;
        logic busy;
        logic dpd;
        logic rst_armed;
        logic so;
        logic so_drive;
        logic op_start;
        logic vol_wr;
        logic suspend;
        logic resume;
        logic abort;
        cmd_req_type req;
    } state_type;

endpackage : flash_status_pkg

// File: flash_status_write_enable.sv
/*
 * Status register and write-enable gating of a serial flash device.
 * Decodes single-line serial frames sampled on sys_clk, keeps the status
 * byte, and hands accepted program, erase and register writes to an
 * array engine that answers with op_done.
 * Assumes sck, cs_n, si and wp_n are synchronous to sys_clk and sck is
 * slower than sys_clk / 2; area_protected is a combinational decode of
 * op_req.addr and block_protect made outside.
 */
`include "flash_status_regs.svh"

// What this block does
// - Eight-bit status byte, documented layout, reset zero
// - Busy flag read-only, set during writes
// - While busy, ignore all but reads, resets, suspend
// - Suspend accepted while program or erase busy
// - Completion clears busy, commands accepted again
// - Write-enable instruction sets the latch
// - Latch low blocks program, erase, register writes
// - Volatile register sets need no latch
// - Write-disable instruction clears the latch
// - Latch clears when a write completes
// - Status write data never alters the latch
// - Status write stores bits seven to two
// - Status read returns live status byte
// - Opcode 02h is latch-gated page program
// - Opcodes 32h, 38h four-line program, gated
// - Sector, block, chip erases gated on latch
// - Register writes, info row ops gated
// - B9h enters, ABh leaves deep power-down
// - Bit six enables four-line data functions
// - Block-protect bits select protected blocks
// - Bit seven write-protects the status byte
// - Lock bit plus low protect pin, four-line off, ignores status writes
// - Four-line enable turns protect, hold into data
// - Refuse program, erase to protected area
module flash_status_write_enable
    import flash_status_pkg::*;
#(
    parameter bit LARGE_DENSITY = 1'b1,
    parameter logic [7:0] OPC_WRITE_ENABLE = 8'h06,
    parameter logic [7:0] OPC_WRITE_DISABLE = 8'h04,
    parameter logic [7:0] OPC_STATUS_READ = 8'h05,
    parameter logic [7:0] OPC_FUNC_READ = 8'h48,
    parameter logic [7:0] OPC_EXT_READ = 8'h81,
    parameter logic [7:0] OPC_VOL_READ_SET = 8'hC0,
    parameter logic [7:0] OPC_VOL_EXT_SET = 8'h83,
    parameter logic [7:0] OPC_RESET_ENABLE = 8'h66,
    parameter logic [7:0] OPC_RESET = 8'h99
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Serial pins
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic wp_n,
    output logic so,
    output logic so_oe_n,
    // Pin roles
    output logic wp_pin_is_data,
    output logic hold_pin_is_data,
    // Array engine side
    output cmd_req_type op_req,
    output logic op_start,
    input wire logic op_done,
    input wire logic area_protected,
    output logic vol_wr,
    output logic suspend_req,
    output logic resume_req,
    output logic abort_req,
    // Status view
    output logic [7:0] status_q,
    output logic [3:0] block_protect,
    output logic deep_power_down
);

    state_type st_q;
    state_type st_d;
    logic sck_rise;
    logic sck_fall;
    logic cs_rise;
    logic [7:0] status_byte;
    logic [7:0] new_op;
    logic hw_locked;

    // Status byte assembled from its parts
    assign status_byte = {st_q.nv, st_q.write_enable_latch, st_q.busy};
    assign sck_rise = sck && !st_q.sck;
    assign sck_fall = !sck && st_q.sck;
    assign cs_rise = cs_n && !st_q.cs_n;
    assign new_op = {st_q.shreg[6:0], si};
    // Hardware lock only while the protect pin still has that role
    assign hw_locked = st_q.nv[5] && !wp_n && !st_q.nv[4];

    // Next state
    always_comb begin
        logic allowed_busy;
        op_kind_type kind;
        logic len_ok;
        logic refuse;
        allowed_busy = 1'b0;
        kind = OPK_NONE;
        len_ok = 1'b0;
        refuse = 1'b0;
        st_d = st_q;
        st_d.sck = sck;
        st_d.cs_n = cs_n;
        st_d.op_start = 1'b0;
        st_d.vol_wr = 1'b0;
        st_d.suspend = 1'b0;
        st_d.resume = 1'b0;
        st_d.abort = 1'b0;
        // Completion ends busy whatever the outcome
        if (op_done && st_q.busy) begin
            st_d.busy = 1'b0;
            st_d.write_enable_latch = 1'b0;
            if (st_q.req.kind == OPK_STATUS_WR) begin
                st_d.nv = st_q.pend;
            end
        end
        if (cs_n) begin
            st_d.phase = PH_IDLE;
            st_d.cnt = 6'h00;
            st_d.so_drive = 1'b0;
            if (cs_rise && st_q.phase == PH_BODY) begin
                st_d.rst_armed = 1'b0;
                case (st_q.opcode)
                    `OPC_PAGE_PROG: kind = OPK_PROG;
                    `OPC_PAGE_PROG_4A, `OPC_PAGE_PROG_4B: kind = OPK_PROG4;
                    `OPC_SECTOR_ERASE_A, `OPC_SECTOR_ERASE_B:
                        kind = OPK_ERASE_SECTOR;
                    `OPC_HALF_BLOCK_ERASE: kind = OPK_ERASE_HALF;
                    `OPC_BLOCK_ERASE: begin
                        // Small densities treat this code as a 32KB erase
                        kind = LARGE_DENSITY ? OPK_ERASE_BLOCK
                                             : OPK_ERASE_HALF;
                    end
                    `OPC_ARRAY_ERASE_A, `OPC_ARRAY_ERASE_B:
                        kind = OPK_ERASE_ALL;
                    `OPC_STATUS_WRITE: kind = OPK_STATUS_WR;
                    `OPC_FUNC_WRITE: kind = OPK_FUNC_WR;
                    `OPC_INFO_ERASE: kind = OPK_INFO_ERASE;
                    `OPC_INFO_PROG: kind = OPK_INFO_PROG;
                    default: kind = OPK_NONE;
                endcase
                // Frame must end on a whole field
                case (kind)
                    OPK_PROG, OPK_PROG4, OPK_INFO_PROG:
                        len_ok = st_q.cnt >= `LEN_PROG_MIN
                                 && st_q.cnt[2:0] == 3'h0;
                    OPK_ERASE_SECTOR, OPK_ERASE_HALF, OPK_ERASE_BLOCK,
                    OPK_INFO_ERASE:
                        len_ok = st_q.cnt == `LEN_ADDR;
                    OPK_ERASE_ALL: len_ok = st_q.cnt == `LEN_OPCODE;
                    OPK_STATUS_WR, OPK_FUNC_WR:
                        len_ok = st_q.cnt == `LEN_REG_WRITE;
                    default: len_ok = 1'b0;
                endcase
                // Protection checks
                case (kind)
                    OPK_PROG, OPK_PROG4, OPK_ERASE_SECTOR, OPK_ERASE_HALF,
                    OPK_ERASE_BLOCK: refuse = area_protected;
                    OPK_ERASE_ALL:
                        refuse = area_protected
                                 || st_q.nv[3:0] != 4'h0;
                    OPK_STATUS_WR: refuse = hw_locked;
                    default: refuse = 1'b0;
                endcase
                if (kind != OPK_NONE) begin
                    // Without the latch no operation starts and busy stays low
                    if (len_ok && st_q.write_enable_latch && !st_q.busy && !refuse) begin
                        st_d.busy = 1'b1;
                        st_d.op_start = 1'b1;
                        st_d.req.kind = kind;
                        st_d.req.data = st_q.shreg[7:0];
                        if (st_q.cnt == `LEN_ADDR) begin
                            st_d.req.addr = st_q.shreg[23:0];
                        end
                        if (kind == OPK_STATUS_WR) begin
                            // Latch bit of the written byte is dropped
                            st_d.pend = st_q.shreg[7:2];
                        end
                    end
                end else if (st_q.opcode == OPC_WRITE_ENABLE) begin
                    if (st_q.cnt == `LEN_OPCODE) begin
                        st_d.write_enable_latch = 1'b1;
                    end
                end else if (st_q.opcode == OPC_WRITE_DISABLE) begin
                    if (st_q.cnt == `LEN_OPCODE) begin
                        st_d.write_enable_latch = 1'b0;
                    end
                end else if (st_q.opcode == `OPC_SLEEP_ENTER) begin
                    st_d.dpd = st_q.cnt == `LEN_OPCODE;
                end else if (st_q.opcode == `OPC_SLEEP_EXIT) begin
                    st_d.dpd = 1'b0;
                end else if (st_q.opcode == `OPC_SUSPEND) begin
                    st_d.suspend = st_q.busy;
                end else if (st_q.opcode == `OPC_RESUME) begin
                    st_d.resume = !st_q.busy;
                end else if (st_q.opcode == OPC_RESET_ENABLE) begin
                    st_d.rst_armed = 1'b1;
                end else if (st_q.opcode == OPC_RESET) begin
                    if (st_q.rst_armed) begin
                        st_d.abort = 1'b1;
                        st_d.busy = 1'b0;
                        st_d.write_enable_latch = 1'b0;
                    end
                end else if (st_q.opcode == OPC_VOL_READ_SET
                             || st_q.opcode == OPC_VOL_EXT_SET) begin
                    // Volatile settings skip the latch entirely
                    if (st_q.cnt == `LEN_REG_WRITE && !st_q.busy) begin
                        st_d.vol_wr = 1'b1;
                        st_d.req.data = st_q.shreg[7:0];
                        st_d.req.kind = st_q.opcode == OPC_VOL_READ_SET
                                        ? OPK_VOL_READ : OPK_VOL_EXT;
                    end
                end
            end
        end else begin
            if (st_q.phase == PH_IDLE) begin
                st_d.phase = PH_OPCODE;
            end
            if (sck_rise && st_q.phase != PH_IGNORE) begin
                st_d.shreg = {st_q.shreg[30:0], si};
                if (st_q.cnt != `LEN_SAT) begin
                    st_d.cnt = st_q.cnt + 6'h01;
                end
                if (st_q.cnt == `LEN_ADDR - 6'h01
                    && st_q.phase == PH_BODY && !st_q.busy) begin
                    st_d.req.addr = {st_q.shreg[22:0], si};
                end
                // Opcode complete: decide what the frame may do
                if (st_q.cnt == `LEN_OPCODE - 6'h01) begin
                    st_d.opcode = new_op;
                    allowed_busy = new_op == OPC_STATUS_READ
                        || new_op == OPC_FUNC_READ
                        || new_op == OPC_EXT_READ
                        || new_op == OPC_RESET_ENABLE
                        || new_op == OPC_RESET
                        || new_op == `OPC_SUSPEND;
                    if (st_q.dpd && new_op != `OPC_SLEEP_EXIT) begin
                        st_d.phase = PH_IGNORE;
                    end else if (st_q.busy && !allowed_busy) begin
                        st_d.phase = PH_IGNORE;
                    end else if (new_op == OPC_STATUS_READ) begin
                        st_d.phase = PH_STATUS_OUT;
                    end else begin
                        st_d.phase = PH_BODY;
                    end
                end
            end
            // Live status, so busy polling sees completion mid-frame
            if (sck_fall && st_q.phase == PH_STATUS_OUT) begin
                st_d.so = status_byte[3'd7 - st_q.cnt[2:0]];
                st_d.so_drive = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
            st_q.phase <= PH_IDLE;
            st_q.sck <= 1'b0;
            st_q.cs_n <= 1'b1;
            st_q.nv <= `SR_NV_RESET_VAL;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register
    assign so = st_q.so;
    assign so_oe_n = !st_q.so_drive;
    assign status_q = status_byte;
    assign block_protect = st_q.nv[3:0];
    assign deep_power_down = st_q.dpd;
    assign wp_pin_is_data = st_q.nv[4];
    assign hold_pin_is_data = st_q.nv[4];
    assign op_req = st_q.req;
    assign op_start = st_q.op_start;
    assign vol_wr = st_q.vol_wr;
    assign suspend_req = st_q.suspend;
    assign resume_req = st_q.resume;
    assign abort_req = st_q.abort;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence write_enable_cmd_frame;
        cs_rise && st_q.phase == PH_BODY
        && st_q.opcode == OPC_WRITE_ENABLE && st_q.cnt == `LEN_OPCODE;
    endsequence

    sequence write_disable_cmd_frame;
        cs_rise && st_q.phase == PH_BODY
        && st_q.opcode == OPC_WRITE_DISABLE && st_q.cnt == `LEN_OPCODE;
    endsequence

    a_wel_gates_start: assert property (op_start |-> $past(st_q.write_enable_latch))
        else $error("operation started without write enable");
    a_start_sets_busy: assert property (op_start |-> status_q[0] && !$past(st_q.busy))
        else $error("start not tied to busy rising");
    a_done_clears: assert property (op_done && st_q.busy |=> !st_q.busy && !st_q.write_enable_latch)
        else $error("completion left busy or latch set");
    a_write_enable_cmd_sets_wel: assert property (write_enable_cmd_frame |=> st_q.write_enable_latch)
        else $error("write enable did not set latch");
    a_write_disable_cmd_clears_wel: assert property (write_disable_cmd_frame |=> !st_q.write_enable_latch)
        else $error("write disable did not clear latch");
    a_lock_blocks_wr: assert property (op_start && op_req.kind == OPK_STATUS_WR |-> !$past(hw_locked))
        else $error("status write accepted while locked");
    a_status_wr_wel: assert property (op_start && op_req.kind == OPK_STATUS_WR |-> st_q.write_enable_latch == $past(st_q.write_enable_latch))
        else $error("status write changed the latch");
    a_status_shift: assert property (sck_fall && !cs_n && st_q.phase == PH_STATUS_OUT |=> so == $past(status_byte[3'd7 - st_q.cnt[2:0]]) && !so_oe_n)
        else $error("status bit out of order");
    a_suspend_busy: assert property (suspend_req |-> $past(st_q.busy, 2))
        else $error("suspend issued while idle");
    a_protect_refuse: assert property (op_start && op_req.kind inside {OPK_PROG, OPK_PROG4, OPK_ERASE_SECTOR} |-> !$past(area_protected))
        else $error("write to protected area started");

endmodule : flash_status_write_enable

// File: flash_host_model.sv
/*
 * Host controller model: sends serial frames MSB first, reads back.
 * Assumes the device samples sck on sys_clk and drives so after falls.
 */
module flash_host_model (
    // Clock
    input wire logic sys_clk,
    // Serial pins
    output logic sck,
    output logic cs_n,
    output logic si,
    input wire logic so
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle pins: deselected, clock parked low
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end

    // One frame: n bits out, then rn bits in; sck idles low (mode 0)
    task automatic frame(input logic [47:0] bits, input int n,
                         input int rn, output logic [7:0] rd);
        rd = 8'h00;
        @(negedge sys_clk);
        cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            si = bits[i];
            repeat (3) @(negedge sys_clk);
            sck = 1'b1;
            repeat (2) @(negedge sys_clk);
            sck = 1'b0;
        end
        // Read after the fall settles; device needs one cycle to update
        for (int i = 0; i < rn; i++) begin
            repeat (3) @(negedge sys_clk);
            rd = {rd[6:0], so};
            sck = 1'b1;
            repeat (2) @(negedge sys_clk);
            sck = 1'b0;
        end
        repeat (2) @(negedge sys_clk);
        cs_n = 1'b1;
        si = ~si; // Released line shows no stale value
        repeat (3) @(negedge sys_clk);
    endtask : frame
endmodule : flash_host_model

// File: testbench.sv
/*
 * Self-checking bench of the status and write-enable block.
 * Assumes the host model drives the pins; the bench plays array engine.
 */
module testbench
    import flash_status_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic sys_clk, resetn, wp_n, op_done, area_prot;
    wire sck, cs_n, si;
    logic so, so_oe_n, wpd, hpd, op_start, vol_wr, susp, resm, abrt, dpd;
    cmd_req_type op_req;
    logic [7:0] status_q, rd;
    logic [3:0] bp;
    int err_count, check_count, n_start, n_vol, n_susp, cyc;
    int n_abrt, n_resm;
    op_kind_type last_kind;

    flash_host_model host (.sys_clk(sys_clk), .sck(sck), .cs_n(cs_n),
        .si(si), .so(so));
    flash_status_write_enable dut (.sys_clk(sys_clk), .resetn(resetn),
        .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n), .so(so),
        .so_oe_n(so_oe_n), .wp_pin_is_data(wpd), .hold_pin_is_data(hpd),
        .op_req(op_req), .op_start(op_start), .op_done(op_done),
        .area_protected(area_prot), .vol_wr(vol_wr), .suspend_req(susp),
        .resume_req(resm), .abort_req(abrt), .status_q(status_q),
        .block_protect(bp), .deep_power_down(dpd));

    always #50 sys_clk = ~sys_clk;

    // Pulse counters: pulses last one cycle, so they are caught here
    always @(posedge sys_clk) begin
        cyc++;
        if (op_start === 1'b1) begin
            n_start++;
            last_kind = op_req.kind;
        end
        if (vol_wr === 1'b1) n_vol++;
        if (susp === 1'b1) n_susp++;
        if (abrt === 1'b1) n_abrt++;
        if (resm === 1'b1) n_resm++;
        if (cyc == 60000) begin
            err_count++;
            print_verdict();
        end
    end

    task automatic chk8(input string nm, input logic [7:0] e, g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk8

    task automatic chk_i(input string nm, input int e, g);
        check_count++;
        if (g != e) begin
            err_count++;
            $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
        end
    endtask : chk_i

    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict

    // Frame of n bits: opcode on top, payload below
    task automatic send(input logic [7:0] op, input int n,
                        input logic [39:0] pay);
        host.frame((48'(op) << (n - 8)) | 48'(pay), n, 0, rd);
    endtask : send

    // Engine reports completion with a one-cycle pulse
    task automatic finish_op();
        @(negedge sys_clk);
        op_done = 1'b1;
        @(negedge sys_clk);
        op_done = 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask : finish_op

    task automatic t_reset();
        chk8("status", 8'h00, status_q);
        chk8("oe_n", 8'h01, so_oe_n);
        host.frame(48'h05, 8, 8, rd);
        chk8("status_read_cmd", 8'h00, rd);
    endtask : t_reset

    // Every latch-gated opcode: refused without latch, taken with it
    task automatic t_gates();
        logic [7:0] ops[13] = '{8'h02, 8'h32, 8'h38, 8'hD7, 8'h20, 8'h52,
            8'hD8, 8'hC7, 8'h60, 8'h01, 8'h42, 8'h64, 8'h62};
        int lens[13] = '{40, 40, 40, 32, 32, 32, 32, 8, 8, 16, 16, 32, 40};
        op_kind_type k[13] = '{OPK_PROG, OPK_PROG4, OPK_PROG4,
            OPK_ERASE_SECTOR, OPK_ERASE_SECTOR, OPK_ERASE_HALF,
            OPK_ERASE_BLOCK, OPK_ERASE_ALL, OPK_ERASE_ALL, OPK_STATUS_WR,
            OPK_FUNC_WR, OPK_INFO_ERASE, OPK_INFO_PROG};
        int n0;
        for (int i = 0; i < 13; i++) begin
            n0 = n_start;
            send(ops[i], lens[i], 40'h0);
            chk_i("no start", n0, n_start);
            chk8("status", 8'h00, status_q);
            send(8'h06, 8, 40'h0);
            chk8("latch", 8'h02, status_q);
            send(ops[i], lens[i], 40'h0);
            chk_i("start", n0 + 1, n_start);
            chk8("kind", 8'(k[i]), 8'(last_kind));
            chk8("busy", 8'h03, status_q);
            finish_op();
            chk8("done", 8'h00, status_q);
        end
    endtask : t_gates

    task automatic t_busy();
        send(8'h06, 8, 40'h0);
        send(8'h02, 40, 40'h0);
        send(8'h04, 8, 40'h0);
        chk8("write_disable_cmd busy", 8'h03, status_q);
        host.frame(48'h05, 8, 8, rd);
        chk8("status_read_cmd busy", 8'h03, rd);
        send(8'h75, 8, 40'h0);
        chk_i("suspend", 1, n_susp);
        send(8'h66, 8, 40'h0);
        send(8'h99, 8, 40'h0);
        chk8("reset", 8'h00, status_q);
        chk_i("abort", 1, n_abrt);
        send(8'h06, 8, 40'h0);
        send(8'h04, 8, 40'h0);
        chk8("write_disable_cmd", 8'h00, status_q);
    endtask : t_busy

    task automatic t_status();
        int n0;
        send(8'h06, 8, 40'h0);
        send(8'h01, 16, 40'hFF);
        chk8("wsr busy", 8'h03, status_q);
        finish_op();
        chk8("wsr", 8'hFC, status_q);
        chk8("bp", 8'h0F, bp);
        chk8("pins", 8'h03, {wpd, hpd});
        n0 = n_start;
        send(8'h06, 8, 40'h0);
        send(8'hC7, 8, 40'h0);
        chk_i("erase bp", n0, n_start);
        area_prot = 1'b1;
        send(8'hD7, 32, 40'h0);
        area_prot = 1'b0;
        chk_i("protected", n0, n_start);
        send(8'h06, 8, 40'h0);
        send(8'h01, 16, 40'h80);
        finish_op();
        chk8("lock set", 8'h80, status_q);
        chk8("pins off", 8'h00, {wpd, hpd});
        wp_n = 1'b0;
        send(8'h06, 8, 40'h0);
        send(8'h01, 16, 40'h00);
        chk8("locked", 8'h82, status_q);
        wp_n = 1'b1;
        send(8'h06, 8, 40'h0);
        send(8'h01, 16, 40'h00);
        finish_op();
        chk8("unlocked", 8'h00, status_q);
    endtask : t_status

    task automatic t_misc();
        send(8'hC0, 16, 40'hA5);
        chk_i("vol", 1, n_vol);
        chk8("vol data", 8'hA5, op_req.data);
        send(8'hB9, 8, 40'h0);
        chk8("dpd", 8'h01, dpd);
        send(8'h06, 8, 40'h0);
        chk8("dpd write_enable_cmd", 8'h00, status_q);
        send(8'hAB, 8, 40'h0);
        chk8("wake", 8'h00, dpd);
        send(8'h7A, 8, 40'h0);
        chk_i("resume", 1, n_resm);
        // Erase address is the 24 bits after the opcode
        send(8'h06, 8, 40'h0);
        send(8'hD7, 32, 40'h123456);
        chk_i("addr", 32'h00123456, int'(op_req.addr));
        finish_op();
        chk8("addr done", 8'h00, status_q);
    endtask : t_misc

    initial begin
        sys_clk = 1'b0;
        resetn = 1'b0;
        wp_n = 1'b1;
        op_done = 1'b0;
        area_prot = 1'b0;
        repeat (10) @(negedge sys_clk);
        resetn = 1'b1;
        repeat (2) @(negedge sys_clk);
        t_reset();
        t_gates();
        t_busy();
        t_status();
        t_misc();
        print_verdict();
    end
endmodule : testbench
